//--- rtl/crw_pkg.sv
// Package with constants for the runaway reset supervision counter
package crw_pkg;
	// Supervision interval: 2^20 oscillation clock periods
	localparam int          CRW_INTERVAL_LOG2  = 20;
	// Reset pulse width in machine cycles
	localparam int          CRW_PULSE_CYCLES   = 5;
	// Extra detection time on standby recovery, in ns
	localparam int          CRW_STANDBY_EXT_NS = 20000;
	// System clock period in ns (40 MHz)
	localparam int          CRW_CLK_PERIOD_NS  = 25;
	// Extra cycles, least time so rounded up
	localparam int          CRW_STANDBY_EXT_CYC =
		(CRW_STANDBY_EXT_NS + CRW_CLK_PERIOD_NS - 1) / CRW_CLK_PERIOD_NS;
	localparam int          CRW_EXT_W          = 11;
	localparam logic [CRW_EXT_W-1:0] CRW_EXT_ZERO = 11'h000;
	localparam logic [2:0]  CRW_PULSE_ZERO     = 3'h0;
	// Watchdog sequence states, Gray coded
	typedef enum logic [1:0] {
		CRW_ST_COUNT  = 2'b00,
		CRW_ST_EXTEND = 2'b01,
		CRW_ST_PULSE  = 2'b11
	} crw_state_t;
endpackage

//--- rtl/crw_watchdog.sv
// Runaway reset supervision counter with low-voltage reset gating
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - The counter runs by itself once the power-on reset is released.
// RL2 - Software clears the counter before 2^20 oscillation clock periods pass.
// RL3 - A timeout with no clear raises the internal reset output.
// RL4 - The timeout reset pulse lasts exactly five machine cycles.
// RL5 - In standby recovery the detection period is the maximum interval plus 20 us.
// RL6 - The counter halts and never times out while the processor is stopped.
// RL7 - A write of zero to the counter clear bit clears the counter.
// RL8 - Internal reset, oscillator stop, sleep, timebase or watch entry clear the counter.
// RL9 - A low-voltage reset during an internal RAM write waits until the write ends.
// RL10 - The low-voltage reset output is suppressed while an internal reset is out.
// RL11 - Each clear restarts from zero and a started pulse always runs its full width.

// The interval counter runs on the oscillation tick enable and the reset
// pulse on the machine tick enable; both come from dividers on mclk_i.
// A clear that meets a wrap in the same cycle wins, so software that clears
// at the last moment never sees a spurious reset.
// Clears are ignored during the pulse: a half-length reset is worse than
// a late restart of the counter.
// The low-voltage detector is the only input from outside the clock
// domain; every other input is assumed to come from logic on mclk_i.
module crw_watchdog
#(
	parameter int CNT_W    = crw_pkg::CRW_INTERVAL_LOG2,
	parameter int EXT_CYC  = crw_pkg::CRW_STANDBY_EXT_CYC
)
(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic osc_tick_i,
	input  wire logic mach_tick_i,
	input  wire logic clr_wr_i,
	input  wire logic counter_clear_bit_i,
	input  wire logic cpu_stopped_i,
	input  wire logic standby_recover_i,
	input  wire logic int_reset_i,
	input  wire logic osc_stop_i,
	input  wire logic sleep_entry_i,
	input  wire logic tbt_watch_entry_i,
	input  wire logic lv_detect_i,
	input  wire logic ram_write_i,
	output logic      wdt_reset_o,
	output logic      lv_reset_o
);
	import crw_pkg::*;

	// Count at which the reset pulse ends on the next machine tick
	localparam logic [2:0] PULSE_LAST = 3'h1;
	// Widest interval counter the increment path is built for
	localparam int         CNT_W_MAX  = 31;
	// Widest extension the down counter can hold
	localparam int         EXT_MAX    = (1 << CRW_EXT_W) - 1;
	// Largest pulse length the three-bit pulse counter can hold
	localparam int         PULSE_MAX  = 7;

	// Refuse widths and counts the counters cannot hold
	generate
		if (CNT_W < 2 || CNT_W > CNT_W_MAX)
		begin : g_bad_cnt_w
			$error("crw_watchdog: CNT_W out of range");
		end
		if (EXT_CYC < 1 || EXT_CYC > EXT_MAX)
		begin : g_bad_ext_cyc
			$error("crw_watchdog: EXT_CYC out of range");
		end
		if (CRW_PULSE_CYCLES < 1 || CRW_PULSE_CYCLES > PULSE_MAX)
		begin : g_bad_pulse
			$error("crw_watchdog: pulse length out of range");
		end
	endgenerate

	// One oscillation period of counting; a stopped CPU freezes the count
	function automatic logic crw_advance
	(
		input logic tick,
		input logic stopped
	);
		return tick && !stopped;
	endfunction

	// Tick that ends the reset pulse; the state and the output share it
	// so that both agree on the final cycle
	function automatic logic crw_pulse_end
	(
		input logic       tick,
		input logic [2:0] count
	);
		return tick && (count == PULSE_LAST);
	endfunction

	crw_state_t          state_reg;
	logic [CNT_W-1:0]    cnt_reg;
	logic [CRW_EXT_W-1:0] ext_reg;
	logic [2:0]          pulse_reg;
	logic                lv_sync1_reg;
	logic                lv_sync2_reg;
	logic                clear_req;
	logic                wrap;
	logic                sw_clear;
	logic                hw_clear;
	logic                advance;
	logic                pulse_end;

	// Only a written zero clears; a written one is ignored
	assign sw_clear  = clr_wr_i && !counter_clear_bit_i;                     // RL7
	// Every internal cause clears, so a recovered core starts afresh
	assign hw_clear  = int_reset_i
		|| osc_stop_i
		|| sleep_entry_i
		|| tbt_watch_entry_i;                                            // RL8
	assign clear_req = sw_clear || hw_clear;
	// Counting and pulse end, decoded once for all users
	assign advance   = crw_advance(osc_tick_i, cpu_stopped_i);               // RL1 RL6
	assign pulse_end = crw_pulse_end(mach_tick_i, pulse_reg);                // RL4
	assign wrap      = advance && (&cnt_reg);

	// Sequence: count, optional standby extension, reset pulse
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= CRW_ST_COUNT;
			cnt_reg   <= '0;
			ext_reg   <= CRW_EXT_ZERO;
			pulse_reg <= CRW_PULSE_ZERO;
		end
		else
		begin
			case (state_reg)
				CRW_ST_COUNT:
				begin
					if (clear_req)
						cnt_reg <= '0;                                 // RL11
					else if (wrap)
					begin
						cnt_reg <= '0;
						if (standby_recover_i)
						begin
							state_reg <= CRW_ST_EXTEND;            // RL5
							ext_reg   <= CRW_EXT_W'(EXT_CYC - 1);
						end
						else
						begin
							state_reg <= CRW_ST_PULSE;             // RL3
							pulse_reg <= 3'(CRW_PULSE_CYCLES);
						end
					end
					else if (advance)                             // RL1 RL6
						cnt_reg <= cnt_reg + 1'b1;
				end
				CRW_ST_EXTEND:
				begin
					// Stopped CPU holds the extension too
					if (clear_req)
						state_reg <= CRW_ST_COUNT;
					else if (!cpu_stopped_i)                       // RL6
					begin
						if (ext_reg == CRW_EXT_ZERO)
						begin
							state_reg <= CRW_ST_PULSE;             // RL5
							pulse_reg <= 3'(CRW_PULSE_CYCLES);
						end
						else
							ext_reg <= ext_reg - 1'b1;
					end
				end
				CRW_ST_PULSE:
				begin
					// Clears ignored until pulse ends
					cnt_reg <= '0;                                     // RL11
					if (pulse_end)
					begin
						state_reg <= CRW_ST_COUNT;
						pulse_reg <= CRW_PULSE_ZERO;
					end
					else if (mach_tick_i)
					begin
						pulse_reg <= pulse_reg - 1'b1;             // RL4
					end
				end
				default:
					state_reg <= CRW_ST_COUNT;
			endcase
		end
	end

	// Registered reset output
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			wdt_reset_o <= 1'b0;
		else
			wdt_reset_o <= (state_reg == CRW_ST_PULSE)              // RL3 RL4
				&& !pulse_end;
	end

	// Detector is analog, so synchronise it first
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lv_sync1_reg <= 1'b0;
			lv_sync2_reg <= 1'b0;
		end
		else
		begin
			lv_sync1_reg <= lv_detect_i;
			lv_sync2_reg <= lv_sync1_reg;
		end
	end

	// Low-voltage reset held off by RAM writes and internal reset
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			lv_reset_o <= 1'b0;
		else
			lv_reset_o <= lv_sync2_reg && !ram_write_i               // RL9
				&& !wdt_reset_o && !int_reset_i;                       // RL10
	end
endmodule

//--- testbench/crw_watchdog_props.sv
// Checker for the supervision counter outputs
`timescale 1ns/1ps
module crw_chk #(parameter int CNT_W = 4, parameter int EXT_CYC = 3)
(
	input wire logic mclk_i, rst_i, osc_tick_i, mach_tick_i, clr_wr_i, counter_clear_bit_i,
	input wire logic cpu_stopped_i, standby_recover_i, int_reset_i, osc_stop_i,
	input wire logic sleep_entry_i, tbt_watch_entry_i, ram_write_i, wdt_reset_o, lv_reset_o
);
	logic [4:0] tk_reg;
	// Ticks taken a cycle late, as the output lags the state; the last tick
	// is still in bit 4 when the fall is seen
	always_ff @(posedge mclk_i or posedge rst_i)
		if (rst_i) tk_reg <= 5'h00;
		else tk_reg <= {mach_tick_i, wdt_reset_o ? tk_reg[3:0] + {3'h0, tk_reg[4]} : 4'h0};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_held; wdt_reset_o [*4]; endsequence
	sequence s_clr; clr_wr_i && !counter_clear_bit_i; endsequence
	a_pulse_width: assert property ($fell(wdt_reset_o) |-> tk_reg[4] && tk_reg[3:0] == 4'h4)
		else $error("width");
	a_pulse_held: assert property ($rose(wdt_reset_o) |-> s_held) else $error("cut");
	a_rise_cause: assert property ($rose(wdt_reset_o) && !$past(standby_recover_i, 2)
		|-> $past(osc_tick_i, 2)) else $error("cause");
	a_stop_halts: assert property (cpu_stopped_i ##2 1 |-> !$rose(wdt_reset_o))
		else $error("stop");
	a_clear_wins: assert property (s_clr ##2 1 |-> !$rose(wdt_reset_o)) else $error("clr");
	a_event_clears: assert property ((int_reset_i || osc_stop_i || sleep_entry_i
		|| tbt_watch_entry_i) ##2 1 |-> !$rose(wdt_reset_o)) else $error("event");
	a_lv_ram: assert property (ram_write_i |=> !lv_reset_o) else $error("ram");
	a_lv_gate: assert property (int_reset_i || wdt_reset_o |=> !lv_reset_o) else $error("lv");
endmodule
bind crw_watchdog crw_chk #(.CNT_W(CNT_W), .EXT_CYC(EXT_CYC)) chk_u (.mclk_i, .rst_i,
	.osc_tick_i, .mach_tick_i, .clr_wr_i, .counter_clear_bit_i, .cpu_stopped_i,
	.standby_recover_i, .int_reset_i, .osc_stop_i, .sleep_entry_i, .tbt_watch_entry_i,
	.ram_write_i, .wdt_reset_o, .lv_reset_o);

//--- testbench/test_crw_watchdog.sv
// Bench for the supervision counter
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t value mismatch", $time); end end
module test_crw_watchdog;
	import crw_pkg::*;
	logic mclk_i = 0, rst_i = 1, mt = 0, cw = 0, cb = 1, cs = 0, sr = 0;
	logic ir = 0, os = 0, se = 0, tw = 0, lv = 0, rw = 0, wdt, lvr;
	int fail_count = 0, compares = 0, n, t = 0;
	logic [31:0] rnd = 32'hd094;
	function logic [31:0] xs(logic [31:0] v); v ^= v << 13; v ^= v >> 17; return v ^ (v << 5); endfunction
	localparam int BW     = 4;
	localparam int BX     = 3;
	// Release to first sampled high output: full count (wrap loads the state), output flop, read before update
	localparam int WRAP_N = (1 << BW) + 2;
	crw_watchdog #(.CNT_W(BW), .EXT_CYC(BX)) dut_u (.mclk_i, .rst_i, .osc_tick_i(1'b1),
		.mach_tick_i(mt), .clr_wr_i(cw), .counter_clear_bit_i(cb), .cpu_stopped_i(cs),
		.standby_recover_i(sr), .int_reset_i(ir), .osc_stop_i(os), .sleep_entry_i(se),
		.tbt_watch_entry_i(tw), .lv_detect_i(lv), .ram_write_i(rw), .wdt_reset_o(wdt),
		.lv_reset_o(lvr));
	always #12.5 mclk_i = ~mclk_i;
	// Random machine ticks; ceiling far above the few hundred cycles needed
	always @(posedge mclk_i)
	begin
		rnd <= xs(rnd);
		mt <= rnd[0];
		if (++t > 2000)
		begin
			fail_count++;
			test_done;
		end
	end
	task test_done;
		$display("fail_count %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Reset, then run until the pulse shows; clear sources pulse every 8 cycles
	// Src 1 writes a one (ignored), 7 a zero; outputs read before the edge updates them
	task run(input int src, input bit stb);
		@(posedge mclk_i);
		rst_i <= 1;
		sr <= stb;
		cs <= src == 6;
		cb <= src != 7;
		{cw, ir, os, se, tw} <= 5'h00;
		repeat (5) @(posedge mclk_i);
		`CHK(wdt, 1'b0)
		rst_i <= 0;
		n = 0;
		while (n < 60 && wdt !== 1'b1)
		begin
			@(posedge mclk_i);
			n++;
			{cw, ir, os, se, tw} <= n % 8 ? 5'h00 : src == 7 ? 5'h10 : 5'h10 >> (src - 1);
		end
	endtask
	initial
	begin
		for (int i = 0; i < 8; i++)
		begin
			run(i, 0);
			`CHK(n, i < 2 ? WRAP_N : 60)
		end
		// Stopped CPU keeps any pulse away while the detector path is tried
		@(posedge mclk_i);
		rst_i <= 1;
		cs <= 1;
		repeat (5) @(posedge mclk_i);
		rst_i <= 0;
		lv <= 1;
		repeat (5) @(posedge mclk_i);
		`CHK(lvr, 1'b1)
		ir <= 1;
		repeat (2) @(posedge mclk_i);
		`CHK(lvr, 1'b0)
		ir <= 0;
		rw <= 1;
		repeat (2) @(posedge mclk_i);
		`CHK(lvr, 1'b0)
		rw <= 0;
		repeat (2) @(posedge mclk_i);
		`CHK(lvr, 1'b1)
		run(0, 1);
		`CHK(n, WRAP_N + BX)
		repeat (2) @(posedge mclk_i);
		`CHK(lvr, 1'b0)
		test_done;
	end
endmodule
